/* File: i3ctr_pkg.sv */
// Constants shared by the I3C target configuration and status register bank
package i3ctr_pkg;
    // Register indices as printed (byte offsets)
    localparam logic [7:0] OFF_BUS_TRAITS   = 8'h00;
    localparam logic [7:0] OFF_DEV_TRAITS   = 8'h01;
    localparam logic [7:0] OFF_BUS_ADDR     = 8'h02;
    localparam logic [7:0] OFF_EVT_ENABLE   = 8'h03;
    localparam logic [7:0] OFF_EVT_CAP      = 8'h04;
    localparam logic [7:0] OFF_EVT_REQUEST  = 8'h05;
    localparam logic [7:0] OFF_RETRY        = 8'h06;
    localparam logic [7:0] OFF_WLEN_HIGH    = 8'h07;
    localparam logic [7:0] OFF_WLEN_LOW     = 8'h08;
    localparam logic [7:0] OFF_RLEN_HIGH    = 8'h09;
    localparam logic [7:0] OFF_RLEN_LOW     = 8'h0a;
    localparam logic [7:0] OFF_PAYLOAD      = 8'h0b;
    localparam logic [7:0] OFF_WSPEED       = 8'h0c;
    localparam logic [7:0] OFF_RSPEED       = 8'h0d;
    // Field positions
    localparam int BIT_JOIN       = 3;   // Join bit in event registers
    localparam int BIT_INT        = 0;   // Interrupt bit in event registers
    localparam int BIT_DONE       = 7;   // Address assigned flag
    localparam int DWORD_SHIFT    = 2;   // DWORD index shift
    localparam int TURN_LSB       = 3;   // Turnaround field low bit
    // Codes and reset values
    localparam logic [1:0]  ROLE_TARGET    = 2'h0;
    localparam logic [7:0]  RETRY_RESET    = 8'h08;
    localparam logic [15:0] FIFO_DEPTH     = 16'h0200;
    localparam logic [15:0] LEN_RESET      = 16'h0200;
    localparam logic [7:0]  PAYLOAD_RESET  = 8'h02;
    localparam logic [2:0]  RATE_RESET     = 3'h0;
    localparam logic [2:0]  TURN_RESET     = 3'h0;
    localparam logic [6:0]  ADDR_RESET     = 7'h00;
    // Rate codes: 0 max SCL, 1 8 MHz, 2 6 MHz, 3 4 MHz, 4 2 MHz
    localparam logic [2:0]  RATE_MAX_SCL   = 3'h0;
    localparam logic [2:0]  RATE_2MHZ      = 3'h4;
    // Turnaround codes: 0..4 for 8..12 ns, 7 beyond 12 ns
    localparam logic [2:0]  TURN_PRIVATE   = 3'h7;
endpackage

/* File: i3ctr_regs.sv */
// Configuration, control and status register bank of the I3C target
`timescale 1ns/10ps
module i3ctr_regs
    import i3ctr_pkg::*;
#(
    parameter logic       JOIN_CAP     = 1'b1,  // Hot-join built in
    parameter logic       INT_CAP      = 1'b1,  // In-band interrupt built in
    parameter logic [7:0] PAYLOAD_SIZE = 8'h01, // Build payload size
    parameter logic       SPEED_LIMIT  = 1'b1,  // Speed limitation built in
    parameter logic [7:0] DCR_CODE     = 8'h00, // Device traits code
    parameter logic       DWORD_ADDR   = 1'b0   // 1: DWORD addressing
)(
    input  wire logic        I_CLK,            // System clock
    input  wire logic        I_RESETN,         // Sync reset, active low
    // Local register port
    input  wire logic        I_REQUEST,        // Start a transaction
    input  wire logic        I_WR_RDN,         // 1 write, 0 read
    input  wire logic [31:0] I_ADDR,           // Register address
    input  wire logic [31:0] I_WDATA,          // Write data
    output logic      [31:0] O_RDATA,          // Read data
    output logic             O_RDATA_VALID,    // Read data valid pulse
    output logic             O_READY,          // Ready for a transaction
    // Events from the bus command engine
    input  wire logic        I_ADDR_ASSIGN,    // Address assigned pulse
    input  wire logic [6:0]  I_NEW_ADDR,       // Assigned address
    input  wire logic        I_ADDR_RESET,     // Address reset command
    input  wire logic        I_JOIN_ENABLE,    // Enable join command
    input  wire logic        I_JOIN_DISABLE,   // Disable join command
    input  wire logic        I_INT_ENABLE,     // Enable interrupt command
    input  wire logic        I_INT_DISABLE,    // Disable interrupt command
    input  wire logic        I_JOIN_DONE,      // Join completed
    input  wire logic        I_JOIN_NACK,      // Join refused
    input  wire logic        I_INT_DONE,       // Interrupt completed
    input  wire logic        I_INT_NACK,       // Interrupt refused
    input  wire logic        I_SET_WRITE_LEN,  // Write length command
    input  wire logic [15:0] I_WRITE_LEN,      // Requested write length
    input  wire logic        I_SET_READ_LEN,   // Read length command
    input  wire logic [15:0] I_READ_LEN,       // Requested read length
    input  wire logic        I_SET_PAYLOAD,    // Payload byte present
    input  wire logic [7:0]  I_PAYLOAD_LEN,    // Requested payload limit
    // State towards the bus engine
    output logic             O_JOIN_GO,        // Raise hot-join
    output logic             O_INT_GO,         // Raise interrupt
    output logic             O_ADDR_VALID,     // Dynamic address valid
    output logic      [6:0]  O_DYN_ADDR,       // Dynamic address
    output logic      [15:0] O_WRITE_LIMIT,    // Max write length
    output logic      [15:0] O_READ_LIMIT,     // Max read length
    output logic      [7:0]  O_PAYLOAD_LIMIT   // Max payload length
);

    // Whole block state in one record
    typedef struct packed {
        logic        ready;          // Port ready
        logic        rvalid;         // Read answer strobe
        logic [7:0]  rdata;          // Read answer byte
        logic        da_done;        // Address assigned flag
        logic [6:0]  dyn_addr;       // Dynamic address
        logic        join_allowed;   // Join enabled by controller
        logic        int_allowed;    // Interrupt enabled by controller
        logic        join_request;   // Software join request
        logic        int_request;    // Software interrupt request
        logic [7:0]  retry_limit;    // Retry limit, zero unlimited
        logic [7:0]  retry_cnt;      // Retries spent on current event
        logic [15:0] wlen;           // Max write length
        logic [15:0] rlen;           // Max read length
        logic [7:0]  payload;        // Max payload length
        logic [2:0]  write_rate_code;
        logic [2:0]  read_rate_code;
        logic [2:0]  turnaround_code;
        logic        join_go;        // Registered join launch
        logic        int_go;         // Registered interrupt launch
    } i3ctr_state_s;

    i3ctr_state_s s;        // Current state
    i3ctr_state_s next_s;   // Next state

    // Build-time derived bits and per-cycle port decode
    logic       payload_bit;     // Payload follows an interrupt
    logic       advanced_bit;    // Pending-read byte supported
    logic [7:0] bus_traits;      // Bus traits read value
    logic [7:0] idx;             // Decoded register index
    logic       wr_req;          // Write taken this cycle
    logic       rd_req;          // Read taken this cycle
    logic       sw_join_set;     // Software sets join request
    logic       sw_int_set;      // Software sets interrupt request
    logic [7:0] wbyte;           // Low write byte

    assign payload_bit  = (PAYLOAD_SIZE != 8'h00);
    assign advanced_bit = INT_CAP & payload_bit;
    // Role, virtual and offline bits are constant zero
    assign bus_traits   = {ROLE_TARGET, advanced_bit, 1'b0, 1'b0,
                           payload_bit, INT_CAP, SPEED_LIMIT};

    // DWORD mode never sees byte lanes
    // Address decode: low byte, or DWORD index with the low two bits dropped
    assign idx = DWORD_ADDR ? I_ADDR[DWORD_SHIFT +: 8]
                            : I_ADDR[7:0];
    assign wbyte  = I_WDATA[7:0];
    assign wr_req = I_REQUEST & I_WR_RDN & s.ready;
    assign rd_req = I_REQUEST & ~I_WR_RDN & s.ready;
    assign sw_join_set = wr_req & (idx == OFF_EVT_REQUEST)
                       & wbyte[BIT_JOIN] & JOIN_CAP;
    assign sw_int_set  = wr_req & (idx == OFF_EVT_REQUEST)
                       & wbyte[BIT_INT] & INT_CAP;

    // Larger limits would overrun the FIFO
    // Clamp a requested length to the FIFO depth
    function automatic logic [15:0] clamp_len(input logic [15:0] v);
        clamp_len = (v > FIFO_DEPTH) ? FIFO_DEPTH : v;
    endfunction

    // Next-state logic for the port, the command events and the requests
    always_comb begin
        next_s        = s;
        next_s.ready  = 1'b1;
        next_s.rvalid = 1'b0;

        // Read mux; unmapped and reserved locations answer zero
        if (rd_req) begin
            next_s.rvalid = 1'b1;
            case (idx)
                OFF_BUS_TRAITS:  next_s.rdata = bus_traits;
                OFF_DEV_TRAITS:  next_s.rdata = DCR_CODE;
                OFF_BUS_ADDR:    next_s.rdata = {s.da_done, s.dyn_addr};
                OFF_EVT_ENABLE:  next_s.rdata = {4'h0, s.join_allowed,
                                                 2'h0, s.int_allowed};
                OFF_EVT_CAP:     next_s.rdata = {4'h0, JOIN_CAP,
                                                 2'h0, INT_CAP};
                OFF_EVT_REQUEST: next_s.rdata = {4'h0, s.join_request,
                                                 2'h0, s.int_request};
                OFF_RETRY:       next_s.rdata = s.retry_limit;
                OFF_WLEN_HIGH:   next_s.rdata = s.wlen[15:8];
                OFF_WLEN_LOW:    next_s.rdata = s.wlen[7:0];
                OFF_RLEN_HIGH:   next_s.rdata = s.rlen[15:8];
                OFF_RLEN_LOW:    next_s.rdata = s.rlen[7:0];
                OFF_PAYLOAD:     next_s.rdata = s.payload;
                // Defining-byte bit stays zero
                OFF_WSPEED:      next_s.rdata = SPEED_LIMIT ?
                                     {5'h00, s.write_rate_code} : 8'h00;
                // Split-read flag stays zero
                OFF_RSPEED:      next_s.rdata = SPEED_LIMIT ?
                                     {2'h0, s.turnaround_code,
                                      s.read_rate_code} : 8'h00;
                default:         next_s.rdata = 8'h00;
            endcase
        end

        // Software writes to the writable fields
        if (wr_req) begin
            case (idx)
                OFF_EVT_REQUEST: begin
                    // Writing zero withdraws a pending request
                    next_s.join_request = wbyte[BIT_JOIN] & JOIN_CAP;
                    next_s.int_request  = wbyte[BIT_INT] & INT_CAP;
                    next_s.retry_cnt    = 8'h00;
                end
                // Zero retries without end
                OFF_RETRY:  next_s.retry_limit = wbyte;
                OFF_WSPEED: begin
                    if (SPEED_LIMIT) begin
                        next_s.write_rate_code = wbyte[2:0];
                    end
                end
                OFF_RSPEED: begin
                    if (SPEED_LIMIT) begin
                        next_s.read_rate_code  = wbyte[2:0];
                        next_s.turnaround_code =
                            wbyte[TURN_LSB +: 3];
                    end
                end
                default: begin
                    // Read-only and unmapped: write ignored
                end
            endcase
        end

        // Address assignment; a simultaneous reset loses to the assignment
        if (I_ADDR_ASSIGN) begin
            next_s.da_done  = 1'b1;
            next_s.dyn_addr = I_NEW_ADDR;
        end else if (I_ADDR_RESET) begin
            next_s.da_done  = 1'b0;
            next_s.dyn_addr = ADDR_RESET;
        end

        // Controller enable and disable; disable wins a tie for safety
        if (JOIN_CAP && I_JOIN_DISABLE) begin
            next_s.join_allowed = 1'b0;
        end else if (JOIN_CAP && I_JOIN_ENABLE) begin
            next_s.join_allowed = 1'b1;
        end
        if (INT_CAP && I_INT_DISABLE) begin
            next_s.int_allowed = 1'b0;
        end else if (INT_CAP && I_INT_ENABLE) begin
            next_s.int_allowed = 1'b1;
        end

        // One retry counter serves both events, and join and
        // interrupt are offered independently on their own go outputs
        // Join request: completion, disable or exhausted retries clear it,
        // but a software set in the same cycle wins
        if (s.join_request && !sw_join_set) begin
            if (I_JOIN_DONE || I_JOIN_DISABLE) begin
                next_s.join_request = 1'b0;
                next_s.retry_cnt    = 8'h00;
            end else if (I_JOIN_NACK && s.retry_limit != 8'h00) begin
                if (s.retry_cnt == s.retry_limit) begin
                    next_s.join_request = 1'b0;
                    next_s.retry_cnt    = 8'h00;
                end else begin
                    next_s.retry_cnt = s.retry_cnt + 8'h01;
                end
            end
        end

        // Interrupt request, same policy
        if (s.int_request && !sw_int_set) begin
            if (I_INT_DONE || I_INT_DISABLE) begin
                next_s.int_request = 1'b0;
                next_s.retry_cnt   = 8'h00;
            end else if (I_INT_NACK && s.retry_limit != 8'h00) begin
                if (s.retry_cnt == s.retry_limit) begin
                    next_s.int_request = 1'b0;
                    next_s.retry_cnt   = 8'h00;
                end else begin
                    next_s.retry_cnt = s.retry_cnt + 8'h01;
                end
            end
        end

        // Length limits from the controller, clamped to the FIFO depth
        if (I_SET_WRITE_LEN) begin
            next_s.wlen = clamp_len(I_WRITE_LEN);
        end
        if (I_SET_READ_LEN) begin
            next_s.rlen = clamp_len(I_READ_LEN);
        end
        // An 8-bit limit never exceeds the depth, so the clamp is a guard
        if (I_SET_PAYLOAD && INT_CAP && payload_bit) begin
            next_s.payload = clamp_len({8'h00, I_PAYLOAD_LEN}) > 16'h00ff
                           ? 8'hff : I_PAYLOAD_LEN;
        end

        // Taken from next state: go falls with its request
        // Launch strobes towards the bus engine, held while allowed
        next_s.join_go = next_s.join_request & next_s.join_allowed;
        next_s.int_go  = next_s.int_request & next_s.int_allowed;
    end

    // Sync reset: one clock domain only
    // State register with synchronous reset
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            s                 <= '0;
            s.join_allowed    <= JOIN_CAP;
            s.int_allowed     <= INT_CAP;
            s.retry_limit     <= RETRY_RESET;
            s.wlen            <= LEN_RESET;
            s.rlen            <= LEN_RESET;
            s.payload         <= PAYLOAD_RESET;
            s.write_rate_code <= RATE_RESET;
            s.read_rate_code  <= RATE_RESET;
            s.turnaround_code <= TURN_RESET;
            s.dyn_addr        <= ADDR_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state record
    assign O_RDATA         = {24'h000000, s.rdata};
    assign O_RDATA_VALID   = s.rvalid;
    assign O_READY         = s.ready;
    assign O_JOIN_GO       = s.join_go;
    assign O_INT_GO        = s.int_go;
    assign O_ADDR_VALID    = s.da_done;
    assign O_DYN_ADDR      = s.dyn_addr;
    assign O_WRITE_LIMIT   = s.wlen;
    assign O_READ_LIMIT    = s.rlen;
    assign O_PAYLOAD_LIMIT = s.payload;

    // Checks on the bank behaviour
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);

    a_read_answer: assert property (rd_req |=> O_RDATA_VALID)
        else $error("Read not answered next cycle");
    a_upper_zero: assert property (O_RDATA[31:8] == 24'h000000)
        else $error("Upper read data not zero");
    a_role_target: assert property (
        rd_req && idx == OFF_BUS_TRAITS |=> O_RDATA[7:3] ==
        {ROLE_TARGET, advanced_bit, 2'h0})
        else $error("Bus traits role or fixed bits wrong");
    a_addr_assign: assert property (
        I_ADDR_ASSIGN |=> O_ADDR_VALID && O_DYN_ADDR == $past(I_NEW_ADDR))
        else $error("Dynamic address not recorded");
    a_addr_clear: assert property (
        I_ADDR_RESET && !I_ADDR_ASSIGN |=> !O_ADDR_VALID && O_DYN_ADDR == 0)
        else $error("Dynamic address not cleared");
    a_join_clear: assert property (
        s.join_request && (I_JOIN_DONE || I_JOIN_DISABLE) && !sw_join_set
        |=> !s.join_request && !O_JOIN_GO)
        else $error("Join request not cleared");
    a_int_clear: assert property (
        s.int_request && (I_INT_DONE || I_INT_DISABLE) && !sw_int_set
        |=> !s.int_request && !O_INT_GO)
        else $error("Interrupt request not cleared");
    a_retry_stop: assert property (
        s.join_request && I_JOIN_NACK && !I_JOIN_DONE && !I_JOIN_DISABLE
        && !sw_join_set && s.retry_limit != 0
        && s.retry_cnt == s.retry_limit |=> !s.join_request)
        else $error("Join retried past the limit");
    a_wlen_clamp: assert property (
        I_SET_WRITE_LEN |=> O_WRITE_LIMIT ==
        ($past(I_WRITE_LEN) > FIFO_DEPTH ? FIFO_DEPTH : $past(I_WRITE_LEN)))
        else $error("Write length not clamped");
    a_rlen_clamp: assert property (
        I_SET_READ_LEN |=> O_READ_LIMIT <= FIFO_DEPTH)
        else $error("Read length above depth");
    a_speed_fixed: assert property (
        rd_req && (idx == OFF_WSPEED) |=> O_RDATA[7:3] == 5'h00)
        else $error("Write speed fixed bits not zero");
    a_split_zero: assert property (
        rd_req && (idx == OFF_RSPEED) |=> O_RDATA[7:6] == 2'h0)
        else $error("Split-read flag not zero");

    // Port answers only what was asked
    a_valid_only_read: assert property (O_RDATA_VALID |-> $past(rd_req))
        else $error("Valid without a read");
    a_dev_traits: assert property (
        rd_req && idx == OFF_DEV_TRAITS |=> O_RDATA[7:0] == DCR_CODE)
        else $error("Device traits code wrong");
    // Controller enable and disable commands
    a_join_enable: assert property (
        JOIN_CAP && I_JOIN_ENABLE && !I_JOIN_DISABLE |=> s.join_allowed)
        else $error("Join not enabled");
    a_int_disable: assert property (
        INT_CAP && I_INT_DISABLE |=> !s.int_allowed)
        else $error("Interrupt not disabled");
    // Retry policy: interrupt limit and unlimited join
    a_int_retry_stop: assert property (
        s.int_request && I_INT_NACK && !I_INT_DONE && !I_INT_DISABLE
        && !sw_int_set && s.retry_limit != 0
        && s.retry_cnt == s.retry_limit |=> !s.int_request)
        else $error("Interrupt retried past the limit");
    a_join_unlimited: assert property (
        s.join_request && I_JOIN_NACK && s.retry_limit == 8'h00
        && !I_JOIN_DONE && !I_JOIN_DISABLE
        && !(wr_req && idx == OFF_EVT_REQUEST) |=> s.join_request)
        else $error("Unlimited join retry gave up");
    // Limits change only on controller commands
    a_wlen_hold: assert property (
        !I_SET_WRITE_LEN |=> $stable(O_WRITE_LIMIT))
        else $error("Write length changed unasked");
    a_payload_store: assert property (
        I_SET_PAYLOAD && INT_CAP && payload_bit
        |=> O_PAYLOAD_LIMIT == $past(I_PAYLOAD_LEN))
        else $error("Payload limit not stored");

    // Main scenarios of the bank
    c_join_done: cover property (sw_join_set ##[1:20] I_JOIN_DONE);
    c_int_nack: cover property (s.int_request && I_INT_NACK);
    c_addr_flow: cover property (I_ADDR_ASSIGN ##[1:50] I_ADDR_RESET);
    c_clamp: cover property (I_SET_WRITE_LEN && I_WRITE_LEN > FIFO_DEPTH);
    c_unlimited: cover property (s.join_request && I_JOIN_NACK
        && s.retry_limit == 8'h00);

endmodule

/* File: i3ctr_engine.sv */
// Behavioural bus controller that answers hot-join and interrupt attempts
`timescale 1ns/10ps
module i3ctr_engine (
    input  wire logic i_clk,       // System clock
    input  wire logic i_resetn,    // Sync reset, active low
    input  wire logic i_join_go,   // Target raises hot-join
    input  wire logic i_int_go,    // Target raises interrupt
    input  wire logic i_refuse,    // 1: refuse every attempt
    output logic      o_join_done, // Hot-join accepted
    output logic      o_join_nack, // Hot-join refused
    output logic      o_int_done,  // Interrupt accepted
    output logic      o_int_nack   // Interrupt refused
);
    logic [1:0] slot;              // Cycles up to the next bus slot
    // One attempt every fourth cycle, so the target's registered go
    // level has time to drop before a second answer could follow
    always_ff @(posedge i_clk) begin
        o_join_done <= 1'b0;
        o_join_nack <= 1'b0;
        o_int_done  <= 1'b0;
        o_int_nack  <= 1'b0;
        if (!i_resetn || !(i_join_go || i_int_go)) begin
            slot <= 2'h0;
        end else begin
            slot <= slot + 2'h1;
            // Join wins the address arbitration over an interrupt
            if (slot == 2'h3 && i_join_go) begin
                o_join_done <= !i_refuse;
                o_join_nack <= i_refuse;
            end else if (slot == 2'h3) begin
                o_int_done <= !i_refuse;
                o_int_nack <= i_refuse;
            end
        end
    end
endmodule

/* File: testbench.sv */
// Self-checking testbench of the target register bank
`timescale 1ns/10ps
module testbench;
    import i3ctr_pkg::*;
    logic        clk    = 1'b0;  // 100 MHz system clock
    logic        rstn   = 1'b0;  // Sync reset, active low
    logic        req    = 1'b0;  // Register request
    logic        wr     = 1'b0;  // 1 write, 0 read
    logic [31:0] addr   = '0;    // Register address
    logic [31:0] wdata  = '0;    // Write data
    logic [8:0]  ev     = '0;    // Command pulses
    logic [6:0]  new_a  = '0;    // Address to assign
    logic [15:0] len    = '0;    // Length carried by set commands
    logic        refuse = 1'b0;  // Engine refuses attempts
    logic [31:0] rdata;          // Read data
    logic        rvalid, jgo, igo, jdn, jnk, idn, ink;
    logic        rdy, avld;      // Ready, address valid
    logic [6:0]  dyn;            // Dynamic address
    logic [15:0] wlim, rlim;     // Length limits
    logic [7:0]  plim;           // Payload limit
    logic [31:0] rdw;            // DWORD bank read data
    logic [7:0]  m [16];         // Expected register image
    int          seed = 32'hba24, fails = 0, checked = 0, nacks = 0;
    i3ctr_regs dut (.I_CLK(clk), .I_RESETN(rstn), .I_REQUEST(req),
        .I_WR_RDN(wr), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
        .O_RDATA_VALID(rvalid), .O_READY(rdy), .I_ADDR_ASSIGN(ev[0]),
        .I_NEW_ADDR(new_a), .I_ADDR_RESET(ev[1]), .I_JOIN_ENABLE(ev[2]),
        .I_JOIN_DISABLE(ev[3]), .I_INT_ENABLE(ev[4]),
        .I_INT_DISABLE(ev[5]), .I_JOIN_DONE(jdn), .I_JOIN_NACK(jnk),
        .I_INT_DONE(idn), .I_INT_NACK(ink), .I_SET_WRITE_LEN(ev[6]),
        .I_WRITE_LEN(len), .I_SET_READ_LEN(ev[7]), .I_READ_LEN(len),
        .I_SET_PAYLOAD(ev[8]), .I_PAYLOAD_LEN(len[7:0]), .O_JOIN_GO(jgo),
        .O_INT_GO(igo), .O_ADDR_VALID(avld), .O_DYN_ADDR(dyn),
        .O_WRITE_LIMIT(wlim), .O_READ_LIMIT(rlim), .O_PAYLOAD_LIMIT(plim));
    // DWORD bank; the rotated address keeps the index, junk in [1:0]
    i3ctr_regs #(.DWORD_ADDR(1'b1)) dut_dword (.I_CLK(clk),
        .I_RESETN(rstn), .I_REQUEST(req), .I_WR_RDN(wr),
        .I_ADDR({addr[29:0], addr[31:30]}), .I_WDATA(wdata),
        .O_RDATA(rdw), .O_RDATA_VALID(), .O_READY(),
        .I_ADDR_ASSIGN(ev[0]), .I_NEW_ADDR(new_a), .I_ADDR_RESET(ev[1]),
        .I_JOIN_ENABLE(ev[2]), .I_JOIN_DISABLE(ev[3]), .I_INT_ENABLE(ev[4]),
        .I_INT_DISABLE(ev[5]), .I_JOIN_DONE(jdn), .I_JOIN_NACK(jnk),
        .I_INT_DONE(idn), .I_INT_NACK(ink), .I_SET_WRITE_LEN(ev[6]),
        .I_WRITE_LEN(len), .I_SET_READ_LEN(ev[7]), .I_READ_LEN(len),
        .I_SET_PAYLOAD(ev[8]), .I_PAYLOAD_LEN(len[7:0]), .O_JOIN_GO(),
        .O_INT_GO(), .O_ADDR_VALID(), .O_DYN_ADDR(), .O_WRITE_LIMIT(),
        .O_READ_LIMIT(), .O_PAYLOAD_LIMIT());
    i3ctr_engine partner (.i_clk(clk), .i_resetn(rstn), .i_join_go(jgo),
        .i_int_go(igo), .i_refuse(refuse), .o_join_done(jdn),
        .o_join_nack(jnk), .o_int_done(idn), .o_int_nack(ink));
    always #5 clk = ~clk;
    // Count interrupt refusals to see how often an interrupt was retried
    always @(posedge clk) if (ink === 1'b1) nacks++;
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Writable bits per offset; everything else must hold its value
    function automatic logic [7:0] wm(input logic [7:0] o);
        case (o)
            8'h06:   return 8'hff;
            8'h0c:   return 8'h07;
            8'h0d:   return 8'h3f;
            default: return 8'h00;
        endcase
    endfunction
    // One access; junk in the ignored upper address bits, data as given
    task automatic acc(input logic w, input logic [7:0] o,
                       input logic [31:0] d, output logic [31:0] q);
        logic [31:0] r;
        r = $random(seed);
        @(posedge clk);
        req   <= 1'b1;
        wr    <= w;
        addr  <= {r[31:8], o};
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        #1 q = rdata;
        if (!w) chk("rdata_valid", 32'h1, {31'h0, rvalid});
    endtask
    task automatic chk_all;
        logic [31:0] q;
        for (int a = 0; a < 16; a++) begin
            acc(1'b0, 8'(a), '0, q);
            chk($sformatf("reg_%0h", a), {24'h0, m[a]}, q);
            chk($sformatf("dw_%0h", a), {24'h0, m[a]}, rdw);
        end
        chk("ready", 32'h1, {31'h0, rdy});
        chk("addr_valid", {31'h0, m[2][7]}, {31'h0, avld});
        chk("dyn_addr", {25'h0, m[2][6:0]}, {25'h0, dyn});
        chk("wlen", {16'h0, m[7], m[8]}, {16'h0, wlim});
        chk("rlen", {16'h0, m[9], m[10]}, {16'h0, rlim});
        chk("payload", {24'h0, m[11]}, {24'h0, plim});
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= '0;
    endtask
    // Bounded wait for the target to give up or finish its event
    task automatic settle;
        for (int i = 0; i < 100 && (jgo || igo); i++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        finish_test;
    end
    initial begin
        logic [31:0] q, d;
        logic [7:0]  o;
        logic [15:0] cl;
        m = '{{ROLE_TARGET, 6'h27}, 8'h00, 8'h00, 8'h09, 8'h09, 8'h00,
              8'h08, 8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00,
              8'h00, 8'h00};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk_all;
        for (int k = 0; k < 40; k++) begin
            o = 8'($random(seed)) & 8'h0f;
            d = $random(seed);
            if (o != 8'h05) acc(1'b1, o, d, q);
            if (o != 8'h05) m[o] = (m[o] & ~wm(o)) | (d[7:0] & wm(o));
        end
        chk_all;
        new_a <= 7'($random(seed));
        pulse(0);
        m[2] = {1'b1, new_a};
        chk_all;
        pulse(1);
        m[2] = 8'h00;
        // Lengths: 0x0201 first as the clamp boundary, then random
        for (int k = 0; k < 9; k++) begin
            len <= (k < 3) ? 16'h0201 : 16'($random(seed)) & 16'h03ff;
            pulse(6 + k % 3);
            cl = (len > 16'd512) ? 16'd512 : len;
            if (k % 3 == 0) {m[7], m[8]} = cl;
            if (k % 3 == 1) {m[9], m[10]} = cl;
            if (k % 3 == 2) m[11] = len[7:0];
            chk_all;
        end
        pulse(3);
        pulse(5);
        m[3] = 8'h00;
        chk_all;
        pulse(2);
        pulse(4);
        m[3] = 8'h09;
        acc(1'b1, 8'h05, 32'h08, q);
        settle;
        chk_all;
        acc(1'b1, 8'h06, 32'h02, q);
        refuse <= 1'b1;
        nacks = 0;
        acc(1'b1, 8'h05, 32'h01, q);
        settle;
        m[6] = 8'h02;
        chk("retries", 32'd3, 32'(nacks));
        acc(1'b1, 8'h06, 32'h00, q);
        acc(1'b1, 8'h05, 32'h09, q);
        repeat (60) @(posedge clk);
        m[5] = 8'h09;
        m[6] = 8'h00;
        chk_all;
        pulse(3);
        pulse(5);
        m[3] = 8'h00;
        m[5] = 8'h00;
        chk_all;
        finish_test;
    end
endmodule
